// ### verilog/gpx_pkg.sv
// Package with the register map, field codes and bus carrier of the GPIO block.
package gpx_pkg;
    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int PORT_W = 32;
    localparam int NPORT = 2;
    localparam int NPIN = 64;
    localparam int AW = 8;
    localparam int DW = 32;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_DIR = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_PIN = 8'h10;
    localparam logic [7:0] OFF_MPIN = 8'h18;
    localparam logic [7:0] OFF_SET = 8'h20;
    localparam logic [7:0] OFF_CLR = 8'h28;
    localparam logic [7:0] OFF_NOT = 8'h30;
    localparam logic [7:0] OFF_PISEL0 = 8'h40;
    localparam logic [7:0] OFF_PISEL1 = 8'h44;
    localparam logic [7:0] OFF_PILVL = 8'h48;
    localparam logic [7:0] OFF_PIENR = 8'h4c;
    localparam logic [7:0] OFF_PIENF = 8'h50;
    localparam logic [7:0] OFF_PIRISE = 8'h54;
    localparam logic [7:0] OFF_PIFALL = 8'h58;
    localparam logic [7:0] OFF_PIST = 8'h5c;
    localparam logic [7:0] OFF_GRPCTL = 8'h64;
    localparam logic [7:0] OFF_PMSRC = 8'h68;
    localparam logic [7:0] OFF_PMCFG = 8'h6c;
    localparam logic [7:0] OFF_PMCTL = 8'h70;
    localparam logic [2:0] OFF_GRP_TOP = 3'h4;
    localparam logic [7:0] PAIR_MASK = 8'hf8;
    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int PMCTL_EN = 0;
    localparam int PMCTL_EV = 1;
    localparam int PMCTL_PIN = 2;
    localparam int PMCTL_MATCH = 24;
    localparam int PMCFG_END = 24;
    localparam int GRPCTL_ST = 2;
    localparam logic [31:0] DIR_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] OUT_RST = 32'h0000_0000;
    // ****************************************************************
    // Pattern slice condition codes
    // ****************************************************************
    localparam logic [2:0] PM_ONE = 3'h0;
    localparam logic [2:0] PM_STK_RISE = 3'h1;
    localparam logic [2:0] PM_STK_FALL = 3'h2;
    localparam logic [2:0] PM_STK_BOTH = 3'h3;
    localparam logic [2:0] PM_HIGH = 3'h4;
    localparam logic [2:0] PM_LOW = 3'h5;
    localparam logic [2:0] PM_ZERO = 3'h6;
    localparam logic [2:0] PM_EDGE = 3'h7;
    // ****************************************************************
    // Bus request carrier
    // ****************************************************************
    typedef struct packed {
        logic read;
        logic write;
        logic [AW-1:0] address;
        logic [3:0] byteenable;
        logic [DW-1:0] writedata;
    } gpx_avs_req_s;
endpackage : gpx_pkg

// ### verilog/gpx_gpio.sv
// GPIO ports, pin interrupts, group interrupts and pattern match engine.
// ********************************************************************
// Overview of operation
// - Two 32-bit ports give 64 pins driven by registers unless peripheral-owned.
// - Each pin's direction is set per bit by software at run time.
// - Set and clear registers raise or lower chosen output bits only.
// - Pin reads return the pad level whatever function owns the pin.
// - Per-port mask limits masked reads and writes to unmasked bits.
// - Byte and halfword accesses change only the addressed lanes, except PMCFG writes, which load all 32 bits.
// - One write can load the whole output value of a port.
// - Toggle register inverts output bits written as one.
// - All pins are inputs after reset.
// - Any pin can make an edge or level interrupt request.
// - Two independent group interrupts detect programmable pin combinations.
// - Group interrupts wake from sleep, deep-sleep and power-down.
// - Up to eight selected pins each drive their own interrupt line.
// - Edge pin interrupts fire on rising, falling or both edges.
// - Level pin interrupts are active high or active low.
// - Pin interrupts wake from sleep and deep-sleep.
// - Pattern engine evaluates levels and transitions over eight selected pins.
// - Each product term raises its own interrupt request when met.
// - A pattern match optionally pulses the CPU event signal.
// - The CPU event signal can be routed out to a pin.
// - Pattern match wakes only from active and sleep modes.
// - Interrupt pin selection ignores the pin's function mux setting.
// ********************************************************************
`timescale 1ns/1ps
module gpx_gpio import gpx_pkg::*; #(
    parameter int NPI = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire gpx_avs_req_s avs_req_i,
    output logic [DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [NPIN-1:0] pad_in_i,
    input wire logic [NPIN-1:0] periph_own_i,
    output logic [NPIN-1:0] pad_out_o,
    output logic [NPIN-1:0] pad_oe_o,
    output logic [NPI-1:0] pint_irq_o,
    output logic [1:0] grp_irq_o,
    output logic cpu_event_pulse_o,
    output logic event_pin_o,
    output logic wake_sleep_o,
    output logic wake_deep_o,
    output logic wake_pd_o
);
    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Every access takes two cycles so that read data come from a flop.
    logic done_q;
    logic [DW-1:0] rdata_q;
    wire req = avs_req_i.read | avs_req_i.write;
    wire [AW-1:0] addr = avs_req_i.address;
    wire [3:0] be = avs_req_i.byteenable;
    wire [DW-1:0] wd = avs_req_i.writedata;
    wire [DW-1:0] be32 = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    wire [DW-1:0] wdm = wd & be32;
    wire wr_go = ce_i & avs_req_i.write & done_q;
    wire port = addr[2];
    wire [AW-1:0] pair = addr & PAIR_MASK;
    wire hit_dir = pair == OFF_DIR;
    wire hit_mask = pair == OFF_MASK;
    wire hit_pin = pair == OFF_PIN;
    wire hit_mpin = pair == OFF_MPIN;
    wire hit_set = pair == OFF_SET;
    wire hit_clr = pair == OFF_CLR;
    wire hit_not = pair == OFF_NOT;
    wire hit_grp = addr[7:5] == OFF_GRP_TOP;
    wire grp_g = addr[4];
    wire grp_ena_sel = addr[3];
    assign avs_waitrequest_o = req & ~done_q;
    assign avs_readdata_o = rdata_q;
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] msk,
                                            input logic [DW-1:0] val);
        merge = (old & ~msk) | (val & msk);
    endfunction : merge

    // ****************************************************************
    // Synchroniser
    // ****************************************************************
    logic [NPIN-1:0] s1, s2, s3;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (ce_i) begin
            s1 <= pad_in_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ****************************************************************
    // Port registers
    // ****************************************************************
    logic [NPORT-1:0][PORT_W-1:0] dir, mask, outv, next_out;
    logic [NPORT-1:0][PORT_W-1:0] pin_rd;
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            wire sel = wr_go & (port == p);
            assign pin_rd[p] = pad_in_i[p*PORT_W +: PORT_W];
            assign pad_out_o[p*PORT_W +: PORT_W] = outv[p];
            assign pad_oe_o[p*PORT_W +: PORT_W] =
                dir[p] & ~periph_own_i[p*PORT_W +: PORT_W];
            always_comb begin
                next_out[p] = outv[p];
                if (sel & hit_pin)
                    next_out[p] = merge(outv[p], be32, wd);
                else if (sel & hit_mpin)
                    next_out[p] = merge(outv[p], be32 & ~mask[p], wd);
                else if (sel & hit_set)
                    next_out[p] = outv[p] | wdm;
                else if (sel & hit_clr)
                    next_out[p] = outv[p] & ~wdm;
                else if (sel & hit_not)
                    next_out[p] = outv[p] ^ wdm;
            end
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    dir[p] <= DIR_RST;
                    mask[p] <= MASK_RST;
                    outv[p] <= OUT_RST;
                end else if (ce_i) begin
                    outv[p] <= next_out[p];
                    if (sel & hit_dir)
                        dir[p] <= merge(dir[p], be32, wd);
                    if (sel & hit_mask)
                        mask[p] <= merge(mask[p], be32, wd);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Pin interrupts
    // ****************************************************************
    logic [NPI-1:0][5:0] pisel;
    logic [NPI-1:0] pi_lvl, pi_enr, pi_enf, rise_st, fall_st;
    logic [NPI-1:0] pi_in, pi_prev, pint_req;
    logic [63:0] pisel_w;
    genvar k;
    generate
        for (k = 0; k < NPI; k++) begin : g_pi
            assign pisel_w[k*8 +: 8] = {2'b00, pisel[k]};
            assign pi_in[k] = s2[pisel[k]];
            assign pi_prev[k] = s3[pisel[k]];
        end
    endgenerate
    wire [NPI-1:0] pi_rose = pi_in & ~pi_prev;
    wire [NPI-1:0] pi_fell = ~pi_in & pi_prev;
    wire [NPI-1:0] pi_edge_req = (rise_st & pi_enr) | (fall_st & pi_enf);
    wire [NPI-1:0] pi_lvl_req = pi_enr & ~(pi_in ^ pi_enf);
    assign pint_req = (pi_lvl & pi_lvl_req) | (~pi_lvl & pi_edge_req);
    wire [DW-1:0] pisel_be0 = (wr_go & addr == OFF_PISEL0) ? be32 : '0;
    wire [DW-1:0] pisel_be1 = (wr_go & addr == OFF_PISEL1) ? be32 : '0;
    wire [63:0] pisel_nx = {merge(pisel_w[63:32], pisel_be1, wd),
                            merge(pisel_w[31:0], pisel_be0, wd)};
    wire [NPI-1:0] rise_clr = (wr_go & addr == OFF_PIRISE) ? wdm[NPI-1:0] : '0;
    wire [NPI-1:0] fall_clr = (wr_go & addr == OFF_PIFALL) ? wdm[NPI-1:0] : '0;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pisel <= '0;
            pi_lvl <= '0;
            pi_enr <= '0;
            pi_enf <= '0;
            rise_st <= '0;
            fall_st <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < NPI; i++) begin
                pisel[i] <= pisel_nx[i*8 +: 6];
            end
            if (wr_go & addr == OFF_PILVL & be[0])
                pi_lvl <= wd[NPI-1:0];
            if (wr_go & addr == OFF_PIENR & be[0])
                pi_enr <= wd[NPI-1:0];
            if (wr_go & addr == OFF_PIENF & be[0])
                pi_enf <= wd[NPI-1:0];
            // A new edge wins over a clear in the same cycle.
            rise_st <= (rise_st & ~rise_clr) | pi_rose;
            fall_st <= (fall_st & ~fall_clr) | pi_fell;
        end
    end

    // ****************************************************************
    // Group interrupts
    // ****************************************************************
    logic [1:0][NPORT-1:0][PORT_W-1:0] grp_pol, grp_ena;
    logic [1:0] grp_and, grp_hit, grp_hit_q, grp_st;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_grp
            wire [NPIN-1:0] act = ~(s2 ^ grp_pol[g]);
            wire [NPIN-1:0] ena = grp_ena[g];
            wire any_hit = |(act & ena);
            wire all_hit = (|ena) & (&(act | ~ena));
            assign grp_hit[g] = grp_and[g] ? all_hit : any_hit;
        end
    endgenerate
    wire grp_wr = wr_go & hit_grp;
    wire [1:0] grp_clr = (wr_go & addr == OFF_GRPCTL) ?
        wdm[GRPCTL_ST +: 2] : 2'b00;
    assign grp_irq_o = grp_st;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            grp_pol <= '0;
            grp_ena <= '0;
            grp_and <= '0;
            grp_hit_q <= '0;
            grp_st <= '0;
        end else if (ce_i) begin
            if (grp_wr & ~grp_ena_sel)
                grp_pol[grp_g][port] <= merge(grp_pol[grp_g][port], be32, wd);
            if (grp_wr & grp_ena_sel)
                grp_ena[grp_g][port] <= merge(grp_ena[grp_g][port], be32, wd);
            if (wr_go & addr == OFF_GRPCTL & be[0])
                grp_and <= wd[1:0];
            grp_hit_q <= grp_hit;
            grp_st <= (grp_st & ~grp_clr) | (grp_hit & ~grp_hit_q);
        end
    end

    // ****************************************************************
    // Pattern match engine
    // ****************************************************************
    // Slices chain into product terms; a slice with its end flag closes a
    // term. The last slice always closes one so no term is left open.
    logic [NPI-1:0][2:0] pmsrc, pmcfg;
    logic [NPI-1:0] pm_end, pm_stk, pm_val, pm_prod, pm_match;
    logic pm_en, ev_en, ev_pin_en, match_q;
    wire pm_cfg_wr = wr_go & (addr == OFF_PMSRC | addr == OFF_PMCFG);
    generate
        for (k = 0; k < NPI; k++) begin : g_pm
            wire in_k = pi_in[pmsrc[k]];
            wire rose_k = pi_rose[pmsrc[k]];
            wire fell_k = pi_fell[pmsrc[k]];
            wire stk_set = (pmcfg[k] == PM_STK_RISE & rose_k) |
                           (pmcfg[k] == PM_STK_FALL & fell_k) |
                           (pmcfg[k] == PM_STK_BOTH & (rose_k | fell_k));
            always_comb begin
                case (pmcfg[k])
                    PM_ONE: pm_val[k] = 1'b1;
                    PM_STK_RISE: pm_val[k] = pm_stk[k] | rose_k;
                    PM_STK_FALL: pm_val[k] = pm_stk[k] | fell_k;
                    PM_STK_BOTH: pm_val[k] = pm_stk[k] | rose_k | fell_k;
                    PM_HIGH: pm_val[k] = in_k;
                    PM_LOW: pm_val[k] = ~in_k;
                    PM_ZERO: pm_val[k] = 1'b0;
                    default: pm_val[k] = rose_k | fell_k;
                endcase
            end
            if (k == 0) begin : g_first
                assign pm_prod[k] = pm_val[k];
            end else begin : g_next
                assign pm_prod[k] = pm_val[k] & (pm_end[k-1] | pm_prod[k-1]);
            end
            wire end_k = (k == NPI - 1) | pm_end[k];
            assign pm_match[k] = pm_prod[k] & end_k;
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i)
                    pm_stk[k] <= 1'b0;
                else if (ce_i)
                    pm_stk[k] <= (pm_stk[k] | stk_set) & ~pm_cfg_wr;
            end
        end
    endgenerate
    wire match_any = |pm_match;
    assign pint_irq_o = pm_en ? pm_match : pint_req;
    assign event_pin_o = cpu_event_pulse_o & ev_pin_en;
    assign wake_pd_o = |grp_st;
    assign wake_deep_o = (|grp_st) | (~pm_en & (|pint_req));
    assign wake_sleep_o = (|grp_st) | (|pint_irq_o);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pmsrc <= '0;
            pmcfg <= '0;
            pm_end <= '0;
            pm_en <= 1'b0;
            ev_en <= 1'b0;
            ev_pin_en <= 1'b0;
            match_q <= 1'b0;
            cpu_event_pulse_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_go & addr == OFF_PMSRC)
                pmsrc <= (pmsrc & ~be32[23:0]) | (wd[23:0] & be32[23:0]);
            if (wr_go & addr == OFF_PMCFG) begin
                pmcfg <= wd[23:0];
                pm_end <= wd[PMCFG_END +: 8];
            end
            if (wr_go & addr == OFF_PMCTL & be[0]) begin
                pm_en <= wd[PMCTL_EN];
                ev_en <= wd[PMCTL_EV];
                ev_pin_en <= wd[PMCTL_PIN];
            end
            match_q <= match_any;
            cpu_event_pulse_o <= pm_en & ev_en & match_any & ~match_q;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [DW-1:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_dir)
            rd_mux = dir[port];
        else if (hit_mask)
            rd_mux = mask[port];
        else if (hit_pin)
            rd_mux = pin_rd[port];
        else if (hit_mpin)
            rd_mux = pin_rd[port] & ~mask[port];
        else if (hit_set)
            rd_mux = outv[port];
        else if (hit_grp)
            rd_mux = grp_ena_sel ? grp_ena[grp_g][port] : grp_pol[grp_g][port];
        else begin
            case (addr)
                OFF_PISEL0: rd_mux = pisel_w[31:0];
                OFF_PISEL1: rd_mux = pisel_w[63:32];
                OFF_PILVL: rd_mux = {24'h00_0000, pi_lvl};
                OFF_PIENR: rd_mux = {24'h00_0000, pi_enr};
                OFF_PIENF: rd_mux = {24'h00_0000, pi_enf};
                OFF_PIRISE: rd_mux = {24'h00_0000, rise_st};
                OFF_PIFALL: rd_mux = {24'h00_0000, fall_st};
                OFF_PIST: rd_mux = {24'h00_0000, pint_req};
                OFF_GRPCTL: rd_mux = {28'h000_0000, grp_st, grp_and};
                OFF_PMSRC: rd_mux = {8'h00, pmsrc};
                OFF_PMCFG: rd_mux = {pm_end, pmcfg};
                OFF_PMCTL: rd_mux = {pm_match, 21'h00_0000,
                                     ev_pin_en, ev_en, pm_en};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            done_q <= req & ~done_q;
            if (avs_req_i.read & ~done_q)
                rdata_q <= rd_mux & be32;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_set_raises_bits: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_go & hit_set & ~port |=> (outv[0] & $past(wdm)) == $past(wdm))
        else $error("set write did not raise bits");
    a_clr_lowers_bits: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_go & hit_clr & port |=> (outv[1] & $past(wdm)) == 32'h0000_0000)
        else $error("clear write did not lower bits");
    a_toggle_inverts: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_go & hit_not & ~port |=> outv[0] == ($past(outv[0]) ^ $past(wdm)))
        else $error("toggle result wrong");
    a_mask_keeps_bits: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_go & hit_mpin & ~port & ~(|avs_req_i.byteenable ^ 1'b1) |=>
        (outv[0] & mask[0]) == $past(outv[0] & mask[0]))
        else $error("masked write changed a masked bit");
    a_lane_untouched: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_go & hit_pin & ~port & ~be[0] |=> outv[0][7:0] == $past(outv[0][7:0]))
        else $error("unselected byte lane changed");
    a_rise_captured: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ce_i & pi_rose[0] |=> rise_st[0])
        else $error("rising edge not captured");
    a_level_request: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ~pm_en & pi_lvl[0] & pi_enr[0] & (pi_in[0] == pi_enf[0]) |->
        pint_irq_o[0])
        else $error("level request missing");
    a_event_single: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        cpu_event_pulse_o & ce_i |=> !cpu_event_pulse_o)
        else $error("event pulse longer than one cycle");
    a_pm_no_deep: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        pm_en & (grp_st == 2'b00) |-> !wake_deep_o)
        else $error("pattern match woke from deep-sleep");
    a_sync_two_stage: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ce_i ##1 ce_i |=> s2 == $past(pad_in_i, 2))
        else $error("synchroniser depth wrong");
endmodule : gpx_gpio

// ### verification/gpx_pad_model.sv
// Board-side pad model that settles every pin level.
`timescale 1ns/1ps
module gpx_pad_model (
    input wire logic [63:0] pad_out_i,
    input wire logic [63:0] pad_oe_i,
    input wire logic [63:0] board_i,
    output logic [63:0] pad_in_o
);
    // Undriven pins take the board level, so no pin is left floating.
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_i);
endmodule : gpx_pad_model

// ### verification/gpio_pin_interrupt_pattern_test.sv
// Self-checking bench for the GPIO block, driven over its register bus.
`timescale 1ns/1ps
module gpio_pin_interrupt_pattern_test import gpx_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    gpx_avs_req_s req = '0;
    logic [63:0] own = '0;
    logic [63:0] board = '0;
    logic [31:0] rd;
    logic [31:0] rdata;
    logic wait_o;
    logic [63:0] pin;
    logic [63:0] pout;
    logic [63:0] poe;
    logic [7:0] pint;
    logic [1:0] grp;
    logic ev;
    logic ev_pin;
    logic [2:0] wake;
    logic [3:0] n_ev;
    logic [3:0] n_pin;
    int n_fail = 0;
    int total_checks = 0;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    gpx_gpio uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .pad_in_i(pin), .periph_own_i(own), .pad_out_o(pout),
        .pad_oe_o(poe), .pint_irq_o(pint), .grp_irq_o(grp),
        .cpu_event_pulse_o(ev), .event_pin_o(ev_pin),
        .wake_sleep_o(wake[2]), .wake_deep_o(wake[1]), .wake_pd_o(wake[0]));
    gpx_pad_model pads (.pad_out_i(pout), .pad_oe_i(poe), .board_i(board),
        .pad_in_o(pin));
    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // The request is held until waitrequest is seen low at an edge.
    task automatic xfer(input logic wr_n, input logic [7:0] a,
            input logic [3:0] be, input logic [31:0] d);
        int n;
        req <= '{read: ~wr_n, write: wr_n, address: a, byteenable: be,
            writedata: d};
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wait_o !== 1'b0 && n < 20);
        rd = rdata;
        if (n >= 20) begin
            n_fail++;
            report_and_stop();
        end else begin
            req <= '0;
            @(posedge clk_sys_i);
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, 4'hf, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 4'hf, 32'h0);
        cmp({32'h0, rd}, {32'h0, exp});
    endtask : rdchk
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        cmp(poe, 64'h0);
        rdchk(OFF_DIR, 32'h0);
        $display("test reset done");
        wr(OFF_DIR, 32'hffff_ffff);
        wr(OFF_PIN, 32'ha5a5_5a5a);
        cmp(pout, 64'h0000_0000_a5a5_5a5a);
        wr(OFF_SET, 32'h0000_000f);
        wr(OFF_CLR, 32'h0000_5000);
        wr(OFF_NOT, 32'hff00_0000);
        cmp(pout, 64'h0000_0000_5aa5_0a5f);
        xfer(1'b1, OFF_PIN, 4'h2, 32'hffff_3cff);
        wr(OFF_MASK, 32'hffff_ff00);
        wr(OFF_MPIN, 32'h0000_0081);
        cmp(pout, 64'h0000_0000_5aa5_3c81);
        rdchk(OFF_MPIN, 32'h0000_0081);
        own <= 64'h1;
        @(posedge clk_sys_i);
        cmp(poe, 64'h0000_0000_ffff_fffe);
        rdchk(OFF_PIN, 32'h5aa5_3c80);
        $display("test port done");
        wr(OFF_PISEL0, 32'h0000_0028);
        wr(OFF_PIENR, 32'h1);
        wr(OFF_PIENF, 32'h1);
        wr(OFF_PIRISE, 32'hff);
        wr(OFF_PIFALL, 32'hff);
        cmp({56'h0, pint}, 64'h0);
        board <= 64'h0000_0100_0000_0000;
        repeat (4) @(posedge clk_sys_i);
        cmp({56'h0, pint}, 64'h1);
        rdchk(OFF_PIRISE, 32'h1);
        rdchk(OFF_PIFALL, 32'h0);
        board <= 64'h0;
        repeat (4) @(posedge clk_sys_i);
        rdchk(OFF_PIFALL, 32'h1);
        wr(OFF_PIRISE, 32'h1);
        wr(OFF_PIFALL, 32'h1);
        rdchk(OFF_PIST, 32'h0);
        wr(OFF_PIENF, 32'h0);
        wr(OFF_PILVL, 32'h1);
        repeat (3) @(posedge clk_sys_i);
        cmp({56'h0, pint}, 64'h1);
        cmp({61'h0, wake}, 64'h6);
        board <= 64'h0000_0100_0000_0000;
        repeat (4) @(posedge clk_sys_i);
        cmp({56'h0, pint}, 64'h0);
        $display("test pin interrupt done");
        wr(8'h84, 32'h0000_0200);
        wr(8'h8c, 32'h0000_0200);
        board <= 64'h0000_0300_0000_0000;
        repeat (4) @(posedge clk_sys_i);
        cmp({62'h0, grp}, 64'h1);
        rdchk(OFF_GRPCTL, 32'h4);
        cmp({61'h0, wake}, 64'h7);
        wr(OFF_GRPCTL, 32'h4);
        rdchk(OFF_GRPCTL, 32'h0);
        $display("test group done");
        wr(OFF_PMSRC, 32'h0);
        wr(OFF_PMCFG, 32'h0100_0034);
        wr(OFF_PMCTL, 32'h3);
        repeat (4) @(posedge clk_sys_i);
        cmp({56'h0, pint}, 64'h1);
        rdchk(OFF_PMCTL, 32'h0100_0003);
        cmp({61'h0, wake}, 64'h4);
        wr(OFF_PMCTL, 32'h7);
        board <= 64'h0000_0200_0000_0000;
        repeat (4) @(posedge clk_sys_i);
        cmp({56'h0, pint}, 64'h0);
        board <= 64'h0000_0300_0000_0000;
        n_ev = 4'h0;
        n_pin = 4'h0;
        repeat (6) begin
            @(posedge clk_sys_i);
            n_ev = n_ev + {3'h0, ev};
            n_pin = n_pin + {3'h0, ev_pin};
        end
        cmp({56'h0, n_ev, n_pin}, 64'h11);
        $display("test pattern done");
        report_and_stop();
    end
endmodule : gpio_pin_interrupt_pattern_test
